// [logic/bprx_frame_out.sv]
// How it works
// - In output mode the frame pulse marks stream alignment, updated on active edge.
// - T1 basic: one-cycle pulse at bit 1 of each 193-bit frame.
// - T1 basic option: pulse only every second frame.
// - T1 superframe: one-cycle pulse at bit 1, frame 1 of 12/24-frame superframe.
// - T1 superframe option: pulse only every second superframe.
// - E1 basic: one-cycle pulse at bit 1 of each 256-bit frame.
// - E1 basic option: pulse only every second frame.
// - E1 multiframe: rise at signaling multiframe, fall after CRC multiframe start.
// - Coincident E1 multiframes give one one-cycle pulse each 16 frames.
// - Input pulse is sampled on active edge and, with elastic store in use, realigns outgoing data.
// - Frame pulse pin is an input after reset.
// - PCM output carries the recovered, processed line data.
// - With elastic store in use, output follows backplane timing, else line.
// - PCM may be tristated outside a programmable timeslot group.
// - PCM output is high impedance after reset.
// - PCM output changes only on the active backplane clock edge.
// - Active edge is selectable, rising or falling.
// - Clock pin is input after reset; as output it carries line clock.
// - Signaling output uses channel bits 5 to 8, high impedance after reset.
module bprx_frame_out
    import bprx_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Configuration
    input wire logic cfg_e1_mode,
    input wire logic cfg_align_multi,
    input wire logic cfg_t1_esf,
    input wire logic cfg_every_second,
    input wire logic cfg_fp_output,
    input wire logic cfg_clk_output,
    input wire logic cfg_clk_falling,
    input wire logic cfg_elastic_bypass,
    input wire logic cfg_pcm_enable,
    input wire logic cfg_ts_enable,
    input wire logic [1:0] cfg_ts_group,
    input wire logic [3:0] cfg_crc_offset,
    // Recovered line side
    input wire logic line_clock,
    input wire logic line_valid,
    output logic line_ready,
    input wire logic line_data,
    input wire logic line_sig,
    input wire logic line_frame_mark,
    // Backplane clock pin
    input wire logic bp_rx_clock_i,
    output logic bp_rx_clock_o,
    output logic bp_rx_clock_oe,
    // Backplane frame pulse pin
    input wire logic bp_rx_frame_pulse_i,
    output logic bp_rx_frame_pulse_o,
    output logic bp_rx_frame_pulse_oe,
    // Backplane data pins
    output logic bp_rx_pcm_out,
    output logic bp_rx_pcm_oe,
    output logic bp_rx_signaling_out,
    output logic bp_rx_signaling_oe
);

    // Bits per frame for the selected line standard
    function automatic logic [8:0] frame_len(input logic e1);
        return e1 ? E1_FRAME_BITS : T1_FRAME_BITS;
    endfunction : frame_len

    // Frames per superframe or multiframe
    function automatic logic [5:0] mf_len(input logic e1, input logic esf);
        if (e1) begin
            return E1_MF_FRAMES;
        end
        return esf ? ESF_FRAMES : SF_FRAMES;
    endfunction : mf_len

    logic clk_src;
    logic clk_prev;
    logic active_edge;
    logic fp_in_prev;
    logic fp_in_rise;
    logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
    logic buf_wr;
    logic buf_wr_ptr;
    logic buf_rd;
    logic [1:0] buf_count;
    logic pop;
    logic [BUF_WIDTH-1:0] head;
    logic resync;
    logic [8:0] bit_cnt;
    logic [5:0] frame_cnt;
    logic [8:0] pos_bit;
    logic [5:0] pos_frame;
    logic [5:0] mf;
    logic [8:0] chan_pos;
    logic is_start;
    logic mf_start;
    logic crc_hit;
    logic fp_out;
    logic next_fp;

    // Clock pin drives recovered line clock only when set as output
    always_ff @(posedge clock) begin
        if (srst) begin
            bp_rx_clock_oe <= CLK_OE_RST;
            bp_rx_clock_o <= 1'b0;
        end else begin
            bp_rx_clock_oe <= cfg_clk_output;
            bp_rx_clock_o <= line_clock;
        end
    end

    // Edge detect on whichever clock times the backplane
    assign clk_src = cfg_clk_output ? bp_rx_clock_o : bp_rx_clock_i;
    assign active_edge = cfg_clk_falling ? (clk_prev & ~clk_src)
                                         : (~clk_prev & clk_src);

    always_ff @(posedge clock) begin
        if (srst) begin
            clk_prev <= clk_src; // Pin level, so release shows no false edge
        end else begin
            clk_prev <= clk_src;
        end
    end

    // Input frame pulse, sampled only on the active edge
    always_ff @(posedge clock) begin
        if (srst) begin
            fp_in_prev <= 1'b0;
        end else if (active_edge) begin
            fp_in_prev <= bp_rx_frame_pulse_i;
        end
    end

    // Leading edge only, so a wide pulse does not hold the counters
    assign fp_in_rise = active_edge & ~cfg_fp_output & bp_rx_frame_pulse_i
                        & ~fp_in_prev;

    // Two-entry buffer: a stall by the backplane loses no word
    assign line_ready = (buf_count != 2'(BUF_DEPTH));
    assign buf_wr = line_valid & line_ready;
    assign pop = active_edge & (buf_count != 2'h0);
    assign head = buf_mem[buf_rd];

    always_ff @(posedge clock) begin
        if (srst) begin
            buf_count <= 2'h0;
        end else begin
            buf_count <= buf_count + 2'(buf_wr) - 2'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            buf_wr_ptr <= 1'b0;
            buf_rd <= 1'b0;
        end else begin
            if (buf_wr) begin
                buf_wr_ptr <= ~buf_wr_ptr;
            end
            if (pop) begin
                buf_rd <= ~buf_rd;
            end
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge clock) begin
        if (buf_wr) begin
            buf_mem[buf_wr_ptr] <= {line_frame_mark, line_sig, line_data};
        end
    end

    // Bypass follows line framing, else backplane framing
    assign resync = cfg_elastic_bypass ? (pop & head[2])
                                       : fp_in_rise;
    assign pos_bit = resync ? 9'h000 : bit_cnt;
    assign pos_frame = resync ? 6'h00 : frame_cnt;
    assign mf = mf_len(cfg_e1_mode, cfg_t1_esf);
    assign is_start = (pos_bit == 9'h000);
    assign mf_start = is_start & ((pos_frame == 6'h00) | (pos_frame == mf));

    // Position counters; frame count spans two multiframes for parity
    always_ff @(posedge clock) begin
        if (srst) begin
            bit_cnt <= 9'h000;
            frame_cnt <= 6'h00;
        end else if (active_edge) begin
            if (pos_bit == frame_len(cfg_e1_mode) - 9'h001) begin
                bit_cnt <= 9'h000;
                if (pos_frame == 6'((7'(mf) << 1) - 7'h01)) begin
                    frame_cnt <= 6'h00;
                end else begin
                    frame_cnt <= pos_frame + 6'h01;
                end
            end else begin
                bit_cnt <= pos_bit + 9'h001;
                frame_cnt <= pos_frame;
            end
        end
    end

    // Frame pulse selection per standard and alignment type
    always_comb begin
        next_fp = 1'b0;
        if (!cfg_align_multi) begin
            next_fp = is_start & (~cfg_every_second | ~pos_frame[0]);
        end else if (!cfg_e1_mode) begin
            next_fp = mf_start & (~cfg_every_second
                                  | (pos_frame == 6'h00));
        end else if (is_start & (pos_frame[3:0] == 4'h0)) begin
            next_fp = 1'b1;
        end else if (crc_hit) begin
            next_fp = 1'b0;
        end else begin
            next_fp = fp_out;
        end
    end

    // CRC multiframe start seen at the previous active edge
    always_ff @(posedge clock) begin
        if (srst) begin
            crc_hit <= 1'b0;
        end else if (active_edge) begin
            crc_hit <= is_start & (pos_frame[3:0] == cfg_crc_offset);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fp_out <= 1'b0;
        end else if (active_edge) begin
            fp_out <= next_fp;
        end
    end

    // Pin direction; input after reset until software changes it
    always_ff @(posedge clock) begin
        if (srst) begin
            bp_rx_frame_pulse_oe <= FP_OE_RST;
        end else begin
            bp_rx_frame_pulse_oe <= cfg_fp_output;
        end
    end
    assign bp_rx_frame_pulse_o = fp_out;

    // T1 bit 0 is the framing bit, so channels start one bit later
    assign chan_pos = cfg_e1_mode ? pos_bit : pos_bit - 9'h001;

    // Data out; underrun sends idle ones rather than stale bits
    always_ff @(posedge clock) begin
        if (srst) begin
            bp_rx_pcm_out <= PCM_IDLE;
            bp_rx_signaling_out <= 1'b0;
            bp_rx_pcm_oe <= PCM_OE_RST;
            bp_rx_signaling_oe <= PCM_OE_RST;
        end else if (active_edge) begin
            bp_rx_pcm_out <= pop ? head[0] : PCM_IDLE;
            bp_rx_signaling_out <= pop & head[1]
                & (chan_pos[2:0] >= SIG_FIRST_BIT)
                & (cfg_e1_mode | ~is_start);
            bp_rx_pcm_oe <= cfg_pcm_enable & (~cfg_ts_enable
                | (chan_pos[4:3] == cfg_ts_group));
            bp_rx_signaling_oe <= cfg_pcm_enable & (~cfg_ts_enable
                | (chan_pos[4:3] == cfg_ts_group));
        end
    end

    // Checks
    fp_dir_rst_a: assert property (@(posedge clock)
        $past(srst) && !srst |-> !bp_rx_frame_pulse_oe)
        else $error("frame pulse pin not input after reset");

    pcm_hiz_rst_a: assert property (@(posedge clock)
        $past(srst) && !srst |-> !bp_rx_pcm_oe && !bp_rx_signaling_oe)
        else $error("pcm not high impedance after reset");

    pcm_on_edge_a: assert property (@(posedge clock) disable iff (srst)
        $changed(bp_rx_pcm_out) |-> $past(active_edge))
        else $error("pcm changed away from active edge");

    t1_frame_start_a: assert property (@(posedge clock) disable iff (srst)
        active_edge && !cfg_e1_mode && !cfg_align_multi && !cfg_every_second
        && pos_bit == 9'h000 |=> fp_out)
        else $error("t1 frame pulse missing at bit 1");

    fp_one_cycle_a: assert property (@(posedge clock) disable iff (srst)
        active_edge && fp_out && !cfg_align_multi && pos_bit != 9'h000
        |=> !fp_out)
        else $error("basic frame pulse wider than one cycle");

    every_second_a: assert property (@(posedge clock) disable iff (srst)
        active_edge && !cfg_align_multi && cfg_every_second && pos_frame[0]
        |=> !fp_out)
        else $error("pulse on odd frame with every-second option");

    sf_start_a: assert property (@(posedge clock) disable iff (srst)
        $rose(fp_out) && !cfg_e1_mode && cfg_align_multi
        |-> $past(pos_bit) == 9'h000
            && ($past(pos_frame) == 6'h00 || $past(pos_frame) == $past(mf)))
        else $error("superframe pulse off frame 1");

    mf_fall_a: assert property (@(posedge clock) disable iff (srst)
        active_edge && cfg_e1_mode && cfg_align_multi && crc_hit
        && !(is_start && pos_frame[3:0] == 4'h0) |=> !fp_out)
        else $error("multiframe pulse did not fall after crc start");

    fp_realign_a: assert property (@(posedge clock) disable iff (srst)
        fp_in_rise && !cfg_elastic_bypass |=> bit_cnt == 9'h001)
        else $error("input frame pulse did not realign");

    mark_align_a: assert property (@(posedge clock)
        disable iff (srst)
        pop && head[2] && cfg_elastic_bypass |=> bit_cnt == 9'h001)
        else $error("marked line word did not realign");

    sig_bits_a: assert property (@(posedge clock)
        disable iff (srst)
        active_edge && chan_pos[2:0] < SIG_FIRST_BIT |=> !bp_rx_signaling_out)
        else $error("signaling outside channel bits 5 to 8");

    idle_fill_a: assert property (@(posedge clock)
        disable iff (srst)
        active_edge && !pop |=> bp_rx_pcm_out == PCM_IDLE)
        else $error("underrun did not send idle ones");

    slot_gate_a: assert property (@(posedge clock)
        disable iff (srst)
        active_edge && cfg_ts_enable && chan_pos[4:3] != cfg_ts_group
        |=> !bp_rx_pcm_oe && !bp_rx_signaling_oe)
        else $error("data driven outside its timeslot group");

    clk_dir_a: assert property (@(posedge clock)
        !srst |=> bp_rx_clock_oe == $past(cfg_clk_output))
        else $error("clock pin direction not as configured");

    fp_dir_a: assert property (@(posedge clock)
        !srst |=> bp_rx_frame_pulse_oe == $past(cfg_fp_output))
        else $error("frame pulse direction not as configured");

    mf_pulse_a: assert property (@(posedge clock)
        disable iff (srst)
        active_edge && cfg_e1_mode && cfg_align_multi
        && cfg_crc_offset == 4'h0 && fp_out |=> !fp_out)
        else $error("coincident multiframe pulse wider than one cycle");

endmodule : bprx_frame_out

// [logic/bprx_pkg.sv]
package bprx_pkg;
    // Frame geometry: frame lengths in backplane clock periods, multiframe lengths in frames
    localparam logic [8:0] T1_FRAME_BITS = 9'h0c1; // 193
    localparam logic [8:0] E1_FRAME_BITS = 9'h100; // 256
    localparam logic [5:0] SF_FRAMES = 6'h0c; // 12
    localparam logic [5:0] ESF_FRAMES = 6'h18; // 24
    localparam logic [5:0] E1_MF_FRAMES = 6'h10; // 16
    // Channel bits that carry signaling (bits 5 to 8, zero based 4 to 7)
    localparam logic [2:0] SIG_FIRST_BIT = 3'h4;
    // Buffer in the data path
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 3; // {frame mark, signaling, pcm}
    // Reset values
    localparam logic FP_OE_RST = 1'b0;
    localparam logic PCM_OE_RST = 1'b0;
    localparam logic CLK_OE_RST = 1'b0;
    localparam logic PCM_IDLE = 1'b1;
endpackage : bprx_pkg

// [dv/bprx_bp_model.sv]
module bprx_bp_model (
    // System side
    input wire logic clock,
    input wire logic run,
    input wire logic fp_req,
    // Backplane pins
    output logic bp_clk,
    output logic fp_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    // Phase starts at zero so the clock pin settles low at the first step
    logic [1:0] ph = 2'h0;

    // Clock of four system periods; stands still while run is low
    always @(negedge clock) begin
        if (run) begin
            ph <= ph + 2'h1;
            bp_clk <= ph[1];
        end
    end

    // Pulse follows the request, which the bench holds one period, once
    always @(negedge clock) begin
        fp_drv <= fp_req;
    end
endmodule : bprx_bp_model

// [dv/testbench.sv]
module testbench
    import bprx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BP = 4;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cfg_e1_mode, cfg_align_multi, cfg_t1_esf, cfg_every_second;
    logic cfg_fp_output, cfg_clk_output, cfg_clk_falling;
    logic cfg_elastic_bypass, cfg_pcm_enable, cfg_ts_enable;
    logic [1:0] cfg_ts_group;
    logic [3:0] cfg_crc_offset;
    logic line_clock, line_ready, line_sig;
    logic line_valid = 1'b0;
    logic line_data = 1'b0;
    logic tk = 1'b0;
    logic line_frame_mark, bp_rx_clock_o, bp_rx_clock_oe;
    logic bp_rx_frame_pulse_o, bp_rx_frame_pulse_oe, bp_rx_pcm_out;
    logic bp_rx_pcm_oe, bp_rx_signaling_out, bp_rx_signaling_oe;
    logic bp_clk, fp_drv, run, fp_req, feed, last, s;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int gap = 0;
    int t0;
    // Pin levels resolved from whichever side drives
    wire logic bp_rx_clock_i = bp_rx_clock_oe ? bp_rx_clock_o : bp_clk;
    wire logic bp_rx_frame_pulse_i =
        bp_rx_frame_pulse_oe ? bp_rx_frame_pulse_o : fp_drv;

    bprx_frame_out u_bprx_frame_out (
        .clock, .srst, .cfg_e1_mode, .cfg_align_multi, .cfg_t1_esf,
        .cfg_every_second, .cfg_fp_output, .cfg_clk_output,
        .cfg_clk_falling, .cfg_elastic_bypass, .cfg_pcm_enable,
        .cfg_ts_enable, .cfg_ts_group, .cfg_crc_offset, .line_clock,
        .line_valid, .line_ready, .line_data, .line_sig,
        .line_frame_mark, .bp_rx_clock_i, .bp_rx_clock_o,
        .bp_rx_clock_oe, .bp_rx_frame_pulse_i, .bp_rx_frame_pulse_o,
        .bp_rx_frame_pulse_oe, .bp_rx_pcm_out, .bp_rx_pcm_oe,
        .bp_rx_signaling_out, .bp_rx_signaling_oe
    );
    bprx_bp_model u_bprx_bp_model (
        .clock, .run, .fp_req, .bp_clk, .fp_drv
    );

    always #5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    // Offer a word every cycle; data flips per accepted word, so a lost
    // or doubled word breaks the alternation on the pin
    always @(posedge clock) tk <= line_valid && line_ready;
    always @(negedge clock) begin
        line_valid <= feed;
        if (tk) begin
            line_data <= ~line_data;
        end
    end

    // Data pin may move once per backplane period at most; the idle level
    // forced by reset is no edge move, so reset leaves the gap open
    always @(posedge clock) begin
        last <= bp_rx_pcm_out;
        gap <= srst ? 3 : (bp_rx_pcm_out !== last) ? 0 : gap + 1;
        if (!srst && bp_rx_pcm_out !== last && gap < 3) begin
            fails++;
            $display("[ERR] %0t pcm moved off edge", $time);
        end
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    // Wait for a level on the pulse pin (s=0) or the data enable (s=1)
    task automatic till(input bit s, input logic v);
        int n;
        n = 0;
        while ((s ? bp_rx_pcm_oe : bp_rx_frame_pulse_o) !== v
               && n < 40000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 40000) begin
            fails++;
            $display("[ERR] %0t wait for level ran out", $time);
        end
    endtask : till

    task automatic meas(input logic [3:0] m, input int per, input int wid);
        int t1;
        // New mode settles under reset, so counting starts at frame 0
        @(negedge clock);
        {cfg_clk_falling, cfg_e1_mode, cfg_align_multi, cfg_every_second} = m;
        srst = 1'b1;
        repeat (3) @(negedge clock);
        srst = 1'b0;
        till(0, 1'b0);
        till(0, 1'b1);
        t0 = cyc;
        till(0, 1'b0);
        t1 = cyc;
        till(0, 1'b1);
        chk(t1 - t0 == wid, "pulse width");
        chk(cyc - t0 == per, "pulse period");
    endtask : meas

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // Tests take near 70k cycles; this cuts a hang well after that
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        report_and_stop();
    end

    initial begin
        {cfg_e1_mode, cfg_align_multi, cfg_t1_esf, cfg_every_second} = 4'h0;
        {cfg_fp_output, cfg_clk_output, cfg_clk_falling} = 3'h0;
        {cfg_elastic_bypass, cfg_pcm_enable, cfg_ts_enable} = 3'h0;
        {cfg_ts_group, cfg_crc_offset} = 6'h00;
        {line_clock, line_sig} = 2'h0;
        {line_frame_mark, fp_req, feed} = 3'h0;
        run = 1'b1;
        repeat (3) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        chk(bp_rx_frame_pulse_oe === 1'b0, "pulse pin driven");
        chk(bp_rx_pcm_oe === 1'b0, "pcm driven");
        chk(bp_rx_signaling_oe === 1'b0, "sig driven");
        chk(bp_rx_clock_oe === 1'b0, "clock pin driven");
        feed = 1'b1;
        cfg_fp_output = 1'b1;
        meas(4'h0, T1_FRAME_BITS * BP, BP);
        chk(bp_rx_frame_pulse_oe === 1'b1, "pulse pin idle");
        meas(4'h1, T1_FRAME_BITS * BP * 2, BP);
        meas(4'hc, E1_FRAME_BITS * BP, BP);
        meas(4'h5, E1_FRAME_BITS * BP * 2, BP);
        meas(4'h2, SF_FRAMES * T1_FRAME_BITS * BP, BP);
        meas(4'h3, SF_FRAMES * T1_FRAME_BITS * BP * 2, BP);
        meas(4'h6, E1_MF_FRAMES * E1_FRAME_BITS * BP, BP);
        cfg_crc_offset = 4'h1;
        meas(4'h6, E1_MF_FRAMES * E1_FRAME_BITS * BP,
             (E1_FRAME_BITS + 1) * BP);
        // Bypass: a marked line word, not the pin, sets the frame start
        cfg_elastic_bypass = 1'b1;
        meas(4'h4, E1_FRAME_BITS * BP, BP);
        repeat (400) @(negedge clock);
        line_frame_mark = 1'b1;
        repeat (BP) @(negedge clock);
        line_frame_mark = 1'b0;
        t0 = cyc;
        till(0, 1'b1);
        chk(cyc - t0 <= 3 * BP, "bypass realign");
        cfg_elastic_bypass = 1'b0;
        // Alternating words must reach the pin one per period
        cfg_fp_output = 1'b0;
        cfg_pcm_enable = 1'b1;
        repeat (40) @(negedge clock);
        for (int i = 0; i < 6; i++) begin
            s = bp_rx_pcm_out;
            repeat (BP) @(negedge clock);
            chk((bp_rx_pcm_out ^ s) === 1'b1, "word lost");
        end
        // Stall the backplane: the store fills, refuses, then drains
        run = 1'b0;
        repeat (8) @(negedge clock);
        chk(line_ready === 1'b0, "full store takes");
        feed = 1'b0;
        run = 1'b1;
        repeat (40) @(negedge clock);
        chk(bp_rx_pcm_out === PCM_IDLE, "no idle on underrun");
        // Group 1 slot starts eight bits after an input frame pulse
        feed = 1'b1;
        line_sig = 1'b1;
        cfg_ts_enable = 1'b1;
        cfg_ts_group = 2'h1;
        fp_req = 1'b1;
        t0 = cyc;
        repeat (BP) @(negedge clock);
        fp_req = 1'b0;
        repeat (6) @(negedge clock);
        till(1, 1'b0);
        till(1, 1'b1);
        chk(cyc - t0 >= 8 * BP && cyc - t0 <= 10 * BP, "align");
        t0 = cyc;
        chk(bp_rx_signaling_out === 1'b0, "sig on channel bit 1");
        repeat (4 * BP) @(negedge clock);
        chk(bp_rx_signaling_out === 1'b1, "sig off channel bit 5");
        till(1, 1'b0);
        chk(cyc - t0 == 8 * BP, "slot width");
        feed = 1'b0;
        repeat (20) @(negedge clock);
        // Clock pin driven from the line clock
        cfg_clk_output = 1'b1;
        line_clock = 1'b1;
        repeat (BP) @(negedge clock);
        chk(bp_rx_clock_oe === 1'b1, "clock pin off");
        chk(bp_rx_clock_o === 1'b1, "clock high");
        line_clock = 1'b0;
        repeat (BP) @(negedge clock);
        chk(bp_rx_clock_o === 1'b0, "clock low");
        report_and_stop();
    end
endmodule : testbench
